// *** hdl/odh_pkg.sv ***
package odh_pkg;
  typedef enum logic [1:0] {
    ODH_MODE_SERIAL,
    ODH_MODE_TWI,
    ODH_MODE_M68,
    ODH_MODE_I80
  } odh_mode_t;

  localparam logic [2:0] MODE_PINS_SERIAL = 3'h0;
  localparam logic [2:0] MODE_PINS_TWI    = 3'h2;
  localparam logic [2:0] MODE_PINS_M68    = 3'h4;
  localparam logic [2:0] MODE_PINS_I80    = 3'h6;

  localparam logic [5:0] TWI_ADDR_PREFIX  = 6'h1E;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam int         CTRL_STREAM_BIT  = 7;
  localparam int         CTRL_DC_BIT      = 6;
  localparam int         PIN_SCL          = 0;
  localparam int         PIN_SDA_IN       = 1;
  localparam int         PIN_SDA_OUT      = 2;
  localparam int         COL_W            = 7;
  localparam logic [6:0] COL_RESET        = 7'h00;
  localparam logic [7:0] BYTE_RESET       = 8'h00;
endpackage

// *** hdl/odh_ser_if.sv ***
interface odh_ser_if;
  logic [7:0] byte_data;
  logic       byte_dc;
  logic       byte_tgl;
  modport link (output byte_data, output byte_dc, output byte_tgl);
  modport core (input byte_data, input byte_dc, input byte_tgl);
endinterface

// *** hdl/odh_serial_shift.sv ***
module odh_serial_shift (
  // Link clock and reset
  input  wire logic serial_clk,
  input  wire logic reset_n,
  // Pins
  input  wire logic cs_n,
  input  wire logic serial_data_input,
  input  wire logic dc,
  // Committed bytes
  odh_ser_if.link   ser
);
  logic [6:0] shift_reg;
  logic [2:0] count_reg;
  logic [7:0] byte_reg;
  logic       dc_reg;
  logic       tgl_reg;

  // Clock may stand still, so reset acts without it
  always_ff @(posedge serial_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg <= 7'h00;
      count_reg <= 3'h0;
    end
    else if (!cs_n)
    begin
      shift_reg <= {shift_reg[5:0], serial_data_input};
      count_reg <= count_reg + 3'h1;
    end
    else
      count_reg <= 3'h0;
  end

  always_ff @(posedge serial_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      byte_reg <= odh_pkg::BYTE_RESET;
      dc_reg   <= 1'b0;
      tgl_reg  <= 1'b0;
    end
    else if (!cs_n && count_reg == 3'h7)
    begin
      byte_reg <= {shift_reg, serial_data_input};
      dc_reg   <= dc;
      tgl_reg  <= ~tgl_reg;
    end
  end

  assign ser.byte_data = byte_reg;
  assign ser.byte_dc   = dc_reg;
  assign ser.byte_tgl  = tgl_reg;
endmodule // odh_serial_shift

// *** hdl/odh_host_port.sv ***
module odh_host_port (
  // Clocks and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             serial_clk,
  // Bus pins
  input  wire logic [7:0]       data_in,
  output logic      [7:0]       data_out,
  output logic      [7:0]       data_oe,
  input  wire logic             e_rd,
  input  wire logic             rw_wr,
  input  wire logic             cs_n,
  input  wire logic             dc,
  input  wire logic [2:0]       bus_mode_select_pins,
  // Command decoder side
  input  wire logic [3:0]       cmd_param_len,
  input  wire logic [7:0]       status_in,
  input  wire logic             col_load,
  input  wire logic [6:0]       col_load_value,
  output logic                  cmd_strobe,
  output logic                  param_strobe,
  // Display RAM side
  output logic                  ram_wr_strobe,
  output logic                  ram_rd_strobe,
  output logic      [7:0]       wr_byte,
  output logic      [6:0]       col_addr,
  input  wire logic [7:0]       ram_rdata,
  output odh_pkg::odh_mode_t    bus_mode
);
  typedef enum logic [2:0] {
    TWI_IDLE,
    TWI_ADDR,
    TWI_CTRL,
    TWI_DATA,
    TWI_SKIP
  } odh_twi_t;

  function automatic odh_pkg::odh_mode_t mode_of(input logic [2:0] p);
    unique case (p)
      odh_pkg::MODE_PINS_TWI: mode_of = odh_pkg::ODH_MODE_TWI;
      odh_pkg::MODE_PINS_M68: mode_of = odh_pkg::ODH_MODE_M68;
      odh_pkg::MODE_PINS_I80: mode_of = odh_pkg::ODH_MODE_I80;
      default:                mode_of = odh_pkg::ODH_MODE_SERIAL;
    endcase
  endfunction

  // Pin synchronisers
  logic [7:0] data_m_reg;
  logic [7:0] data_s_reg;
  logic [4:0] ctl_m_reg;
  logic [4:0] ctl_s_reg;
  logic [2:0] sel_m_reg;
  logic [2:0] sel_s_reg;
  logic [2:0] tgl_reg;
  logic [4:0] ctl_p_reg;
  logic [7:0] data_p_reg;
  logic       ser_tgl_w;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_m_reg <= 8'hFF;
      data_s_reg <= 8'hFF;
      data_p_reg <= 8'hFF;
      ctl_m_reg  <= 5'h1F;
      ctl_s_reg  <= 5'h1F;
      ctl_p_reg  <= 5'h1F;
      sel_m_reg  <= 3'h0;
      sel_s_reg  <= 3'h0;
      tgl_reg    <= 3'h0;
    end
    else
    begin
      data_m_reg <= data_in;
      data_s_reg <= data_m_reg;
      data_p_reg <= data_s_reg;
      ctl_m_reg  <= {e_rd, rw_wr, cs_n, dc, 1'b1};
      ctl_s_reg  <= ctl_m_reg;
      ctl_p_reg  <= ctl_s_reg;
      sel_m_reg  <= bus_mode_select_pins;
      sel_s_reg  <= sel_m_reg;
      tgl_reg    <= {tgl_reg[1:0], ser_tgl_w};
    end
  end

  logic e_s;
  logic e_p;
  logic rw_s;
  logic rw_p;
  logic cs_s;
  logic dc_s;
  logic scl_s;
  logic scl_p;
  logic sda_s;
  logic sda_p;
  assign e_s   = ctl_s_reg[4];
  assign e_p   = ctl_p_reg[4];
  assign rw_s  = ctl_s_reg[3];
  assign rw_p  = ctl_p_reg[3];
  assign cs_s  = ctl_s_reg[2];
  assign dc_s  = ctl_s_reg[1];
  assign scl_s = data_s_reg[odh_pkg::PIN_SCL];
  assign scl_p = data_p_reg[odh_pkg::PIN_SCL];
  assign sda_s = data_s_reg[odh_pkg::PIN_SDA_IN];
  assign sda_p = data_p_reg[odh_pkg::PIN_SDA_IN];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      bus_mode <= odh_pkg::ODH_MODE_SERIAL;
    else
      bus_mode <= mode_of(sel_s_reg);
  end

  // Serial link, on its own clock
  odh_ser_if ser ();
  assign ser_tgl_w = ser.byte_tgl;

  odh_serial_shift u_serial (
    .serial_clk        (serial_clk),
    .reset_n           (reset_n),
    .cs_n              (cs_n),
    .serial_data_input (data_in[odh_pkg::PIN_SDA_IN]),
    .dc                (dc),
    .ser               (ser.link)
  );

  logic ser_valid;
  assign ser_valid = (tgl_reg[2] != tgl_reg[1])
                   && bus_mode == odh_pkg::ODH_MODE_SERIAL;

  // Parallel strobes
  logic par_wr;
  logic par_rd;
  always_comb
  begin
    par_wr = 1'b0;
    par_rd = 1'b0;
    if (!cs_s)
    begin
      if (bus_mode == odh_pkg::ODH_MODE_I80)
      begin
        par_wr = rw_s && !rw_p;
        par_rd = e_s && !e_p;
      end
      else if (bus_mode == odh_pkg::ODH_MODE_M68)
      begin
        par_wr = !e_s && e_p && !rw_s;
        par_rd = !e_s && e_p && rw_s;
      end
    end
  end

  // Two-wire receiver
  odh_twi_t   twi_state;
  logic [7:0] twi_shift_reg;
  logic [3:0] twi_bits_reg;
  logic       twi_ack_reg;
  logic       twi_stream_reg;
  logic       twi_dc_reg;
  logic       twi_valid_reg;
  logic       twi_on;
  logic       scl_rise;
  logic       scl_fall;
  logic       twi_start;
  logic       twi_stop;
  logic       addr_hit;

  assign twi_on    = bus_mode == odh_pkg::ODH_MODE_TWI;
  assign scl_rise  = scl_s && !scl_p;
  assign scl_fall  = !scl_s && scl_p;
  assign twi_start = twi_on && scl_s && scl_p && sda_p && !sda_s;
  assign twi_stop  = twi_on && scl_s && scl_p && !sda_p && sda_s;
  assign addr_hit  = twi_shift_reg[7:1]
                   == {odh_pkg::TWI_ADDR_PREFIX, dc_s};

  always_ff @(posedge clk)
  begin
    if (!reset_n || !twi_on)
    begin
      twi_state      <= TWI_IDLE;
      twi_shift_reg  <= odh_pkg::BYTE_RESET;
      twi_bits_reg   <= 4'h0;
      twi_ack_reg    <= 1'b0;
      twi_stream_reg <= 1'b0;
      twi_dc_reg     <= 1'b0;
      twi_valid_reg  <= 1'b0;
    end
    else
    begin
      twi_valid_reg <= 1'b0;
      if (twi_start)
      begin
        twi_state    <= TWI_ADDR;
        twi_bits_reg <= 4'h0;
        twi_ack_reg  <= 1'b0;
      end
      else if (twi_stop)
      begin
        twi_state   <= TWI_IDLE;
        twi_ack_reg <= 1'b0;
      end
      else if (twi_state != TWI_IDLE)
      begin
        // Sampled at clock rise, stable while high
        if (scl_rise && twi_bits_reg < odh_pkg::BITS_PER_BYTE)
        begin
          twi_shift_reg <= {twi_shift_reg[6:0], sda_s};
          twi_bits_reg  <= twi_bits_reg + 4'h1;
        end
        else if (scl_fall && twi_ack_reg)
        begin
          twi_ack_reg  <= 1'b0;
          twi_bits_reg <= 4'h0;
        end
        else if (scl_fall && twi_bits_reg == odh_pkg::BITS_PER_BYTE)
        begin
          unique case (twi_state)
            TWI_ADDR:
            begin
              twi_ack_reg <= addr_hit;
              if (!addr_hit)
                twi_state <= TWI_SKIP;
              else if (twi_shift_reg[0])
                twi_state <= TWI_SKIP;
              else
                twi_state <= TWI_CTRL;
            end
            TWI_CTRL:
            begin
              twi_ack_reg    <= 1'b1;
              twi_stream_reg <= twi_shift_reg[odh_pkg::CTRL_STREAM_BIT];
              twi_dc_reg     <= twi_shift_reg[odh_pkg::CTRL_DC_BIT];
              twi_state      <= TWI_DATA;
            end
            TWI_DATA:
            begin
              twi_ack_reg   <= 1'b1;
              twi_valid_reg <= 1'b1;
              if (twi_stream_reg)
                twi_state <= TWI_CTRL;
            end
            TWI_SKIP:
              twi_bits_reg <= 4'h0;
            TWI_IDLE:
              twi_bits_reg <= 4'h0;
          endcase
        end
      end
    end
  end

  // Merge byte sources
  logic       acc_valid;
  logic [7:0] acc_byte;
  logic       acc_dc;
  always_comb
  begin
    acc_valid = 1'b0;
    acc_byte  = data_s_reg;
    acc_dc    = dc_s;
    if (ser_valid)
    begin
      acc_valid = 1'b1;
      acc_byte  = ser.byte_data;
      acc_dc    = ser.byte_dc;
    end
    else if (twi_valid_reg)
    begin
      acc_valid = 1'b1;
      acc_byte  = twi_shift_reg;
      acc_dc    = twi_dc_reg;
    end
    else if (par_wr)
      acc_valid = 1'b1;
  end

  // Route bytes to command, parameter or RAM
  logic [3:0] param_left_reg;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cmd_strobe     <= 1'b0;
      param_strobe   <= 1'b0;
      ram_wr_strobe  <= 1'b0;
      wr_byte        <= odh_pkg::BYTE_RESET;
      param_left_reg <= 4'h0;
    end
    else
    begin
      cmd_strobe    <= 1'b0;
      param_strobe  <= 1'b0;
      ram_wr_strobe <= 1'b0;
      if (acc_valid)
      begin
        wr_byte <= acc_byte;
        if (!acc_dc)
        begin
          cmd_strobe     <= 1'b1;
          param_left_reg <= cmd_param_len;
        end
        else if (param_left_reg != 4'h0)
        begin
          param_strobe   <= 1'b1;
          param_left_reg <= param_left_reg - 4'h1;
        end
        else
          ram_wr_strobe <= 1'b1;
      end
    end
  end

  // Column pointer
  logic col_step;
  assign col_step = (acc_valid && acc_dc && param_left_reg == 4'h0)
                  || (par_rd && dc_s);
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      col_addr <= odh_pkg::COL_RESET;
    else if (col_load)
      col_addr <= col_load_value;
    else if (col_step)
      col_addr <= col_addr + 7'h01;
  end

  // Pipelined read latch: first data read returns stale byte
  logic [7:0] rd_latch_reg;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_latch_reg  <= odh_pkg::BYTE_RESET;
      ram_rd_strobe <= 1'b0;
    end
    else
    begin
      ram_rd_strobe <= par_rd && dc_s;
      if (par_rd && dc_s)
        rd_latch_reg <= ram_rdata;
    end
  end

  // Pin drivers
  logic rd_drive;
  assign rd_drive = !cs_s && ((bus_mode == odh_pkg::ODH_MODE_I80 && !e_s)
                  || (bus_mode == odh_pkg::ODH_MODE_M68 && rw_s && e_s));
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_out <= odh_pkg::BYTE_RESET;
      data_oe  <= 8'h00;
    end
    else if (rd_drive)
    begin
      data_out <= dc_s ? rd_latch_reg : status_in;
      data_oe  <= 8'hFF;
    end
    else
    begin
      data_out <= odh_pkg::BYTE_RESET;
      data_oe  <= {5'h00, twi_ack_reg, 2'h0};
    end
  end
endmodule // odh_host_port

// *** bench/odh_host_port_props.sv ***
module odh_host_port_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Pins
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  input wire logic       e_rd,
  input wire logic       cs_n,
  input wire logic [2:0] bus_mode_select_pins,
  // Core side
  input wire logic       col_load,
  input wire logic       cmd_strobe,
  input wire logic       param_strobe,
  input wire logic       ram_wr_strobe,
  input wire logic       ram_rd_strobe,
  input wire logic [7:0] wr_byte,
  input wire logic [6:0] col_addr,
  input odh_pkg::odh_mode_t bus_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  logic strb;
  assign strb = cmd_strobe | param_strobe | ram_wr_strobe;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_rst;
    disable iff (1'b0)
    !reset_n |=> col_addr == 7'h00 && data_oe == 8'h00 && !strb;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_i80;
    (bus_mode_select_pins == odh_pkg::MODE_PINS_I80) [*5]
      |-> bus_mode == odh_pkg::ODH_MODE_I80;
  endproperty
  a_i80: assert property (p_i80) else $error("mode i80");
  property p_twi;
    (bus_mode_select_pins == odh_pkg::MODE_PINS_TWI) [*5]
      |-> bus_mode == odh_pkg::ODH_MODE_TWI;
  endproperty
  a_twi: assert property (p_twi) else $error("mode twi");
  property p_ser;
    bus_mode == odh_pkg::ODH_MODE_SERIAL |-> data_oe == 8'h00;
  endproperty
  a_ser: assert property (p_ser) else $error("serial drive");
  property p_idle;
    (bus_mode != odh_pkg::ODH_MODE_TWI && cs_n) [*5] |-> data_oe == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("drive unselected");
  property p_rd;
    (bus_mode == odh_pkg::ODH_MODE_I80 && !cs_n && !e_rd) [*5]
      |-> data_oe == 8'hFF;
  endproperty
  a_rd: assert property (p_rd) else $error("read drive");
  property p_ack;
    bus_mode == odh_pkg::ODH_MODE_TWI && data_oe[2] |-> !data_out[2];
  endproperty
  a_ack: assert property (p_ack) else $error("ack level");
  property p_col;
    ram_wr_strobe && !$past(col_load)
      |-> col_addr == $past(col_addr) + 7'h01;
  endproperty
  a_col: assert property (p_col) else $error("col step");
  property p_rds;
    ram_rd_strobe && !$past(col_load)
      |-> col_addr == $past(col_addr) + 7'h01;
  endproperty
  a_rds: assert property (p_rds) else $error("read step");
  property p_pulse;
    strb |=> !strb [*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe width");
  property p_hold;
    !$stable(wr_byte) |-> strb;
  endproperty
  a_hold: assert property (p_hold) else $error("byte moved");
  c_rd: cover property (ram_rd_strobe);
  c_cmd: cover property (cmd_strobe && bus_mode == odh_pkg::ODH_MODE_TWI);
  c_oe: cover property (data_oe == 8'hFF);
endmodule // odh_host_port_props

bind odh_host_port odh_host_port_props u_props (.clk, .reset_n,
  .data_out, .data_oe, .e_rd, .cs_n, .bus_mode_select_pins, .col_load,
  .cmd_strobe, .param_strobe, .ram_wr_strobe, .ram_rd_strobe, .wr_byte,
  .col_addr, .bus_mode);

// *** bench/odh_host_model.sv ***
module odh_host_model (
  // Clock and device outputs
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  // Host pins
  output logic      [7:0] data_in,
  output logic            e_rd,
  output logic            rw_wr,
  output logic            cs_n,
  output logic            dc,
  output logic            serial_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] m;
  logic [7:0] pbus;
  logic       scl, sda, sbit, wire_sda;
  // Pulled-up line, low while either side pulls it down
  assign wire_sda = sda & ~(data_oe[2] & ~data_out[2]);
  assign data_in = m == 2'h1 ? {6'h00, wire_sda, scl} :
                   m == 2'h2 ? {6'h00, sbit, serial_clk} : pbus;
  initial
  begin
    {m, pbus, scl, sda, sbit, dc, serial_clk} = 15'h0000;
    {e_rd, rw_wr, cs_n, scl, sda} = 5'h1F;
  end
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task idle(input logic [1:0] mode, input logic lvl);
    m = mode;
    e_rd = lvl;
    rw_wr = lvl;
  endtask
  task par(input logic m68, rd, s, d, input logic [7:0] b,
           output logic [7:0] r);
    cs_n = s;
    dc = d;
    pbus = b;
    if (m68)
    begin
      rw_wr = rd;
      e_rd = 1'b1;
    end
    else if (rd)
      e_rd = 1'b0;
    else
      rw_wr = 1'b0;
    w(6);
    r = data_out;
    if (m68)
      e_rd = 1'b0;
    else
      {e_rd, rw_wr} = 2'h3;
    w(6);
    cs_n = 1'b1;
    pbus = ~b;
    if (m68)
      rw_wr = 1'b0;
    w(2);
  endtask
  task spi(input logic d, input logic [7:0] b);
    cs_n = 1'b0;
    dc = d;
    for (int i = 7; i >= 0; i--)
    begin
      sbit = b[i];
      #15 serial_clk = 1'b1;
      #15 serial_clk = 1'b0;
    end
    w(10);
    cs_n = 1'b1;
    sbit = ~sbit;
    w(2);
  endtask
  task tbit(input logic v);
    sda = v;
    w(4);
    scl = 1'b1;
    w(8);
    scl = 1'b0;
    w(4);
  endtask
  task tstart;
    w(8);
    sda = 1'b0;
    w(8);
    scl = 1'b0;
    w(4);
  endtask
  task tstop;
    sda = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    sda = 1'b1;
    w(8);
  endtask
  task tbyte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--)
      tbit(b[i]);
    sda = 1'b1;
    w(4);
    scl = 1'b1;
    w(4);
    a = ~wire_sda;
    w(4);
    scl = 1'b0;
    w(4);
  endtask
endmodule // odh_host_model

// *** bench/test_oled_driver_host_interface.sv ***
module test_oled_driver_host_interface;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk, reset_n, col_load, ack;
  logic               e_rd, rw_wr, cs_n, dc, serial_clk;
  logic               cmd_strobe, param_strobe, ram_wr_strobe, ram_rd_strobe;
  logic [2:0]         bsel;
  logic [3:0]         plen;
  logic [6:0]         col_val, col_addr;
  logic [7:0]         data_in, data_out, data_oe, ram_rdata, wr_byte, rr, eb;
  logic [1:0]         ek;
  odh_pkg::odh_mode_t bus_mode;
  int                 ec, seen, fails, tests_run, cyc, rc;
  // Stand-in RAM: a known byte per column
  assign ram_rdata = {1'b0, col_addr} ^ 8'h5A;
  odh_host_port DUT (.clk, .reset_n, .serial_clk, .data_in, .data_out,
    .data_oe, .e_rd, .rw_wr, .cs_n, .dc, .bus_mode_select_pins(bsel),
    .cmd_param_len(plen), .status_in(8'hA5), .col_load,
    .col_load_value(col_val), .cmd_strobe, .param_strobe, .ram_wr_strobe,
    .ram_rd_strobe, .wr_byte, .col_addr, .ram_rdata, .bus_mode);
  odh_host_model host (.clk, .data_out, .data_oe, .data_in, .e_rd, .rw_wr,
    .cs_n, .dc, .serial_clk);
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ram_rd_strobe)
      rc <= rc + 1;
    if (cmd_strobe | param_strobe | ram_wr_strobe)
    begin
      ek <= {param_strobe | ram_wr_strobe, cmd_strobe | ram_wr_strobe};
      eb <= wr_byte;
      ec <= ec + 1;
    end
    if (cyc == 8000)
    begin
      fails++;
      complete_run();
    end
  end
  task complete_run;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task ev(input logic [1:0] k, input logic [7:0] b);
    if (k != 2'h0)
      seen++;
    chk("strobes", seen[7:0], ec[7:0]);
    if (k != 2'h0)
    begin
      chk("kind", {6'h00, k}, {6'h00, ek});
      chk("wr_byte", b, eb);
    end
  endtask
  task rst(input logic [2:0] p, input logic [1:0] m, input logic lvl,
           input odh_pkg::odh_mode_t e);
    bsel = p;
    host.idle(m, lvl);
    reset_n = 1'b0;
    host.w(6);
    reset_n = 1'b1;
    host.w(6);
    chk("col_addr", 8'h00, {1'b0, col_addr});
    chk("bus_mode", {6'h00, e}, {6'h00, bus_mode});
  endtask
  task wr(input logic m68, s, d, input logic [7:0] b, input logic [1:0] k);
    host.par(m68, 1'b0, s, d, b, rr);
    ev(k, b);
  endtask
  task rd(input logic m68, d, input logic [7:0] e);
    host.par(m68, 1'b1, 1'b0, d, 8'h00, rr);
    chk("read data", e, rr);
  endtask
  task tw(input logic [7:0] b, input logic a, input logic [1:0] k);
    host.tbyte(b, ack);
    chk("ack", {7'h00, a}, {7'h00, ack});
    ev(k, b);
  endtask
  initial
  begin
    {reset_n, col_load, col_val, ec, seen, fails, tests_run, cyc, rc} = 0;
    {bsel, ek, eb} = 13'h0000;
    plen = 4'h1;
    rst(odh_pkg::MODE_PINS_I80, 2'h0, 1'b1, odh_pkg::ODH_MODE_I80);
    wr(0, 0, 0, 8'hAE, 2'h1);
    wr(0, 0, 1, 8'h12, 2'h2);
    wr(0, 0, 1, 8'h34, 2'h3);
    chk("col_addr", 8'h01, {1'b0, col_addr});
    rd(0, 0, 8'hA5);
    host.par(0, 1, 0, 1, 8'h00, rr);
    rd(0, 1, 8'h5B);
    chk("col_addr", 8'h03, {1'b0, col_addr});
    chk("ram_rd_strobe", 8'h02, rc[7:0]);
    wr(0, 1, 0, 8'hAF, 2'h0);
    col_load = 1'b1;
    col_val = 7'h7E;
    host.w(1);
    col_load = 1'b0;
    wr(0, 0, 1, 8'h77, 2'h3);
    chk("col_addr", 8'h7F, {1'b0, col_addr});
    rst(odh_pkg::MODE_PINS_M68, 2'h0, 1'b0, odh_pkg::ODH_MODE_M68);
    wr(1, 0, 0, 8'h81, 2'h1);
    wr(1, 0, 1, 8'h22, 2'h2);
    wr(1, 0, 1, 8'h56, 2'h3);
    wr(1, 1, 0, 8'h5F, 2'h0);
    rd(1, 0, 8'hA5);
    rst(odh_pkg::MODE_PINS_SERIAL, 2'h2, 1'b0, odh_pkg::ODH_MODE_SERIAL);
    host.spi(0, 8'h9C);
    ev(2'h1, 8'h9C);
    host.spi(1, 8'hC3);
    ev(2'h2, 8'hC3);
    host.spi(1, 8'h3D);
    ev(2'h3, 8'h3D);
    plen = 4'h0;
    rst(odh_pkg::MODE_PINS_TWI, 2'h1, 1'b0, odh_pkg::ODH_MODE_TWI);
    host.dc = 1'b1;
    host.tstart();
    tw(8'h7A, 1, 2'h0);
    tw(8'h80, 1, 2'h0);
    tw(8'hA0, 1, 2'h1);
    tw(8'h40, 1, 2'h0);
    tw(8'h11, 1, 2'h3);
    tw(8'h22, 1, 2'h3);
    host.tstop();
    chk("col_addr", 8'h02, {1'b0, col_addr});
    host.tstart();
    tw(8'h78, 0, 2'h0);
    host.tstop();
    host.tstart();
    tw(8'h7B, 1, 2'h0);
    host.tstop();
    complete_run();
  end
endmodule // test_oled_driver_host_interface
